// File: core/sef_flags.v
/*
 spi error, status flag and interrupt request logic with a minimal byte engine.
 assumes cpu strobes are one-cycle pulses on CORE_CLK; SS_N, SCK and MOSI/MISO
 are pins from outside the clock domain; slave data sampled on sck edges.
*/
`default_nettype none
`include "sef_map.vh"
// Overview of operation
// - ss level against mode sets mode fault
// - no mode fault while select disable set
// - mode fault raises receiver/error request
// - mode fault clears enable and master bits
// - status read then control write clears fault
// - data write during transfer sets collision
// - collision: no interrupt, transfer undisturbed
// - status then data access clears collision
// - overrun keeps first byte, drops rest
// - overrun is never flagged
// - slave ss rise mid-byte sets abort
// - abort no interrupt, cleared disabling interface
// - transfer done drives transmitter request
// - fault request only with select enabled
// - slave clock_phase_bit zero ignores select disable
module sef_flags (
	input  wire       CORE_CLK,      // 100 MHz clock
	input  wire       ARST_N,        // async reset, active low
	input  wire       CE,            // clock enable
	input  wire       CTL_WR,        // control register write pulse
	input  wire [7:0] CTL_WDATA,     // control write data
	input  wire       STAT_RD,       // status register read pulse
	input  wire       DATA_WR,       // data register write pulse
	input  wire       DATA_RD,       // data register read pulse
	input  wire [7:0] DATA_WDATA,    // data write data
	input  wire       SS_N,          // slave select pin
	input  wire       SCK_IN,        // serial clock pin in
	input  wire       MOSI_IN,       // serial data pin in
	output reg  [7:0] CTL_Q,         // control register contents
	output reg  [7:0] RX_DATA,       // receive buffer
	output reg        TRANSFER_DONE, // transfer done flag
	output reg        WRITE_COLL,    // write collision flag
	output reg        SELECT_ABORT,  // select abort flag
	output reg        MODE_FAULT,    // mode fault flag
	output reg        TX_IRQ,        // transmitter request
	output reg        RXERR_IRQ,     // receiver/error request
	output reg        SPI_IRQ,       // combined request, level
	output reg        MISO_OUT,      // serial data out
	output reg        MISO_OE_N,     // miso enable, low drives
	output reg        SCK_OUT,       // master serial clock
	output reg        MOSI_OUT       // master serial data
);
	wire ss_s;
	wire sck_s;
	wire mosi_s;
	sef_sync u_ss (
		.clk    (CORE_CLK),
		.arst_n (ARST_N),
		.ce     (CE),
		.d      (SS_N),
		.q      (ss_s)
	);
	// sck resets to its idle level, so no false edge follows reset
	sef_sync #(
		.RST (`SEF_SCK_IDLE)
	) u_sck (
		.clk    (CORE_CLK),
		.arst_n (ARST_N),
		.ce     (CE),
		.d      (SCK_IN),
		.q      (sck_s)
	);
	sef_sync u_mosi (
		.clk    (CORE_CLK),
		.arst_n (ARST_N),
		.ce     (CE),
		.d      (MOSI_IN),
		.q      (mosi_s)
	);

	reg                  sck_d;
	reg                  ss_d;
	reg                  busy;
	reg [`SEF_CNT_W-1:0] bit_cnt;
	reg [`SEF_CNT_W-1:0] half_cnt;
	reg [7:0]            shreg;
	reg                  stat_seen_fault;
	reg                  stat_seen_coll;
	reg                  stat_seen_done;
	wire en     = CTL_Q[`SEF_CTL_EN];
	wire master_select_bit   = CTL_Q[`SEF_CTL_MASTER_SELECT_BIT];
	wire select_pin_disable_bit  = CTL_Q[`SEF_CTL_SELECT_PIN_DISABLE_BIT];
	wire clock_phase_bit   = CTL_Q[`SEF_CTL_CLOCK_PHASE_BIT];
	wire cpol   = CTL_Q[`SEF_CTL_CPOL];
	// slave with clock_phase_bit 0 always honours select
	wire ss_used = !select_pin_disable_bit || (!master_select_bit && !clock_phase_bit);
	wire sck_edge = (sck_s != sck_d);
	wire sample_edge = sck_edge && ((sck_s ^ cpol) != clock_phase_bit);
	wire slave_sel = !master_select_bit && en && (!ss_s || !ss_used);
	wire fault_now = en && master_select_bit && !ss_s && !select_pin_disable_bit;
	wire abort_now = en && !master_select_bit && ss_s && !ss_d && busy && ss_used;
	wire fault_clr = stat_seen_fault && CTL_WR;
	wire coll_clr  = stat_seen_coll && (DATA_WR || DATA_RD);
	wire coll_now  = DATA_WR && busy;
	wire done_clr  = stat_seen_done && (DATA_WR || DATA_RD);
	wire master_step = master_select_bit && en && busy && (half_cnt == `SEF_CNT_ZERO);
	wire slave_sample = slave_sel && sample_edge;
	wire master_select_bit_sample = master_step && (SCK_OUT ^ cpol ^ clock_phase_bit) == 1'b0;
	// master moves mosi on the shift edge, clear of the sample edge
	wire shift_step = master_step && !master_select_bit_sample;
	wire do_sample = slave_sample || master_select_bit_sample;
	wire byte_done = do_sample && (bit_cnt == `SEF_BYTE_END - `SEF_CNT_ONE);
	wire [7:0] next_shreg = {shreg[`SEF_BIT_MSB-1:0], master_select_bit ? 1'b0 : mosi_s};

	always @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			CTL_Q           <= `SEF_CTL_RESET;
			RX_DATA         <= `SEF_BYTE_ZERO;
			TRANSFER_DONE   <= 1'b0;
			WRITE_COLL      <= 1'b0;
			SELECT_ABORT    <= 1'b0;
			MODE_FAULT      <= 1'b0;
			TX_IRQ          <= 1'b0;
			RXERR_IRQ       <= 1'b0;
			SPI_IRQ         <= 1'b0;
			MISO_OUT        <= 1'b0;
			MISO_OE_N       <= 1'b1;
			SCK_OUT         <= 1'b0;
			MOSI_OUT        <= 1'b0;
			sck_d           <= 1'b0;
			ss_d            <= 1'b1;
			busy            <= 1'b0;
			bit_cnt         <= `SEF_CNT_ZERO;
			half_cnt        <= `SEF_CNT_ZERO;
			shreg           <= `SEF_BYTE_ZERO;
			stat_seen_fault <= 1'b0;
			stat_seen_coll  <= 1'b0;
			stat_seen_done  <= 1'b0;
		end else if (CE) begin
			sck_d <= sck_s;
			ss_d  <= ss_s;
			// control register, fault forcing wins over software write
			if (CTL_WR)
				CTL_Q <= CTL_WDATA;
			if (fault_now) begin
				CTL_Q[`SEF_CTL_EN]   <= 1'b0;
				CTL_Q[`SEF_CTL_MASTER_SELECT_BIT] <= 1'b0;
			end
			// status read arms the clearing sequences
			if (STAT_RD) begin
				stat_seen_fault <= MODE_FAULT;
				stat_seen_coll  <= WRITE_COLL;
				stat_seen_done  <= TRANSFER_DONE;
			end else begin
				if (CTL_WR)
					stat_seen_fault <= 1'b0;
				if (DATA_WR || DATA_RD) begin
					stat_seen_coll <= 1'b0;
					stat_seen_done <= 1'b0;
				end
			end
			if (fault_now)
				MODE_FAULT <= 1'b1;
			else if (fault_clr)
				MODE_FAULT <= 1'b0;
			if (coll_now)
				WRITE_COLL <= 1'b1;
			else if (coll_clr)
				WRITE_COLL <= 1'b0;
			if (abort_now)
				SELECT_ABORT <= 1'b1;
			else if (CTL_WR && !CTL_WDATA[`SEF_CTL_EN])
				SELECT_ABORT <= 1'b0;
			// done flag cleared by status read then data access
			if (byte_done)
				TRANSFER_DONE <= 1'b1;
			else if (done_clr)
				TRANSFER_DONE <= 1'b0;
			// byte engine; colliding writes never touch shreg
			if (!en || abort_now) begin
				busy     <= 1'b0;
				bit_cnt  <= `SEF_CNT_ZERO;
				SCK_OUT  <= cpol;
				half_cnt <= `SEF_CNT_ZERO;
			end else if (DATA_WR && !busy) begin
				shreg    <= DATA_WDATA;
				busy     <= master_select_bit;
				bit_cnt  <= `SEF_CNT_ZERO;
				half_cnt <= `SEF_SCK_HALF;
				MOSI_OUT <= DATA_WDATA[`SEF_BIT_MSB];
				MISO_OUT <= DATA_WDATA[`SEF_BIT_MSB];
			end else begin
				// busy from the first sample; a trailing clock_phase_bit 0 edge must not re-arm it
				if (slave_sample)
					busy <= 1'b1;
				if (master_step) begin
					SCK_OUT  <= !SCK_OUT;
					half_cnt <= `SEF_SCK_HALF;
				end else if (master_select_bit && busy)
					half_cnt <= half_cnt - `SEF_CNT_ONE;
				if (do_sample) begin
					shreg   <= next_shreg;
					bit_cnt <= bit_cnt + `SEF_CNT_ONE;
					MISO_OUT <= next_shreg[`SEF_BIT_MSB];
				end
				if (shift_step)
					MOSI_OUT <= shreg[`SEF_BIT_MSB];
				if (byte_done) begin
					busy    <= 1'b0;
					bit_cnt <= `SEF_CNT_ZERO;
					// overrun: keep first byte, silently drop later ones
					if (!TRANSFER_DONE)
						RX_DATA <= next_shreg;
				end
			end
			MISO_OE_N <= !slave_sel;
			TX_IRQ    <= TRANSFER_DONE;
			RXERR_IRQ <= MODE_FAULT && !select_pin_disable_bit;
			SPI_IRQ   <= TRANSFER_DONE || (MODE_FAULT && !select_pin_disable_bit);
		end
	end
endmodule // sef_flags
`default_nettype wire

// File: core/sef_map.vh
/*
 spi error/flag block constants: control bit positions, reset values, timing.
 assumes inclusion by core/sef_flags.v and core/sef_sync.v.
*/
`ifndef SEF_MAP_VH
`define SEF_MAP_VH
`define SEF_BITS           8
`define SEF_BIT_MSB        7
`define SEF_CNT_W          4
`define SEF_CNT_ZERO       4'h0
`define SEF_CNT_ONE        4'h1
`define SEF_BYTE_END       4'h8
`define SEF_BYTE_ZERO      8'h00
`define SEF_CTL_SPR2       7
`define SEF_CTL_EN         6
`define SEF_CTL_SELECT_PIN_DISABLE_BIT      5
`define SEF_CTL_MASTER_SELECT_BIT       4
`define SEF_CTL_CPOL       3
`define SEF_CTL_CLOCK_PHASE_BIT       2
`define SEF_CTL_RESET      8'h14
`define SEF_SYNC_RESET     1'b1
`define SEF_SCK_IDLE       1'b0
`define SEF_SCK_HALF       4'h4
`endif

// File: core/sef_sync.v
/*
 two-flop synchroniser for a pin level.
 assumes d is asynchronous to clk; q is the only output read by logic.
*/
`default_nettype none
`include "sef_map.vh"
module sef_sync #(
	parameter [0:0] RST = `SEF_SYNC_RESET // level held in reset
) (
	input  wire clk,   // core clock
	input  wire arst_n, // async reset
	input  wire ce,    // clock enable
	input  wire d,     // pin level
	output wire q      // synchronised level
);
	reg meta;
	reg stage;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta  <= RST;
			stage <= RST;
		end else if (ce) begin
			meta  <= d;
			stage <= meta;
		end
	end
	assign q = stage;
endmodule // sef_sync
`default_nettype wire

// File: tb/sef_flags_assertions.sv
/* checker for sef_flags with its bind.
 sees top ports only; one clock domain, CE held high. */
`default_nettype none
module sef_chk (
	input wire logic       CORE_CLK,      // clock
	input wire logic       ARST_N,        // reset
	input wire logic       CTL_WR,        // ctl write
	input wire logic [7:0] CTL_WDATA,     // ctl data
	input wire logic [7:0] CTL_Q,         // control
	input wire logic       TRANSFER_DONE, // done
	input wire logic       WRITE_COLL,    // collision
	input wire logic       SELECT_ABORT,  // abort
	input wire logic       MODE_FAULT,    // fault
	input wire logic       TX_IRQ,        // tx req
	input wire logic       RXERR_IRQ,     // rx/err req
	input wire logic       SPI_IRQ        // merged req
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!ARST_N);
	a_fault_forces: assert property ($rose(MODE_FAULT) |-> !CTL_Q[6] && !CTL_Q[4])
		else $error("fault left enable or master");
	a_fault_req: assert property (MODE_FAULT && !CTL_Q[5] |=> RXERR_IRQ)
		else $error("fault raised no request");
	a_fault_mask: assert property (CTL_Q[5] || !MODE_FAULT |=> !RXERR_IRQ)
		else $error("request without enabled fault");
	a_done_req: assert property (TX_IRQ == $past(TRANSFER_DONE))
		else $error("tx request does not follow done");
	a_req_merge: assert property (SPI_IRQ == (TX_IRQ || RXERR_IRQ))
		else $error("merged request wrong");
	a_quiet_flags: assert property ((WRITE_COLL || SELECT_ABORT) && !TRANSFER_DONE
		&& !MODE_FAULT |=> !SPI_IRQ)
		else $error("collision or abort raised request");
	a_abort_hold: assert property (SELECT_ABORT && !(CTL_WR && !CTL_WDATA[6])
		|=> SELECT_ABORT)
		else $error("abort cleared wrongly");
	a_fault_hold: assert property (MODE_FAULT && !CTL_WR |=> MODE_FAULT)
		else $error("fault cleared without control write");
	cover property ($rose(MODE_FAULT));
	cover property ($rose(WRITE_COLL));
	cover property ($rose(SELECT_ABORT));
	cover property ($rose(TRANSFER_DONE));
endmodule // sef_chk
bind sef_flags sef_chk u_chk (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .CTL_WR(CTL_WR),
	.CTL_WDATA(CTL_WDATA), .CTL_Q(CTL_Q), .TRANSFER_DONE(TRANSFER_DONE),
	.WRITE_COLL(WRITE_COLL), .SELECT_ABORT(SELECT_ABORT), .MODE_FAULT(MODE_FAULT),
	.TX_IRQ(TX_IRQ), .RXERR_IRQ(RXERR_IRQ), .SPI_IRQ(SPI_IRQ));
`default_nettype wire

// File: tb/sef_peer.sv
/* remote spi master model on select, clock and data pins.
 assumes clock idle low, data taken on the rising edge; still between frames. */
`default_nettype none
module sef_peer (
	output var logic ss_n, // select
	output var logic sck,  // serial clock
	output var logic mosi  // serial data
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		ss_n = 1'b1;
		sck = 1'b0;
		mosi = 1'b1;
	end
	task sel(input logic v);
		ss_n = v;
	endtask
	// n below 8 ends the frame early
	task send(input logic [7:0] b, input int n);
		ss_n = 1'b0;
		for (int i = 7; i > 7 - n; i--) begin
			#62.5 sck = 1'b0;
			mosi = b[i];
			#62.5 sck = 1'b1;
		end
		#62.5 sck = 1'b0;
		mosi = ~mosi;
		#62.5 ss_n = 1'b1;
		#100;
	endtask
endmodule // sef_peer
`default_nettype wire

// File: tb/sef_flags_test.sv
/* self-checking bench for sef_flags.
 assumes sef_peer as remote master and the bound checker. */
`default_nettype none
module sef_flags_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic CORE_CLK = '0, ARST_N = '0, CTL_WR = '0, STAT_RD = '0, DATA_WR = '0, DATA_RD = '0;
	logic [7:0] CTL_WDATA = '0, DATA_WDATA = '0, b0, b1, cap = '0;
	logic sck_q = '0;
	wire logic MISO_OUT, MISO_OE_N, SCK_OUT, MOSI_OUT;
	wire logic [7:0] CTL_Q, RX_DATA;
	wire logic TRANSFER_DONE, WRITE_COLL, SELECT_ABORT, MODE_FAULT, TX_IRQ, RXERR_IRQ, SPI_IRQ;
	wire logic ss_n, sck, mosi;
	int seed = 32'h1291, bad_count = 0, checked = 0, t = 0;
	always #5 CORE_CLK = ~CORE_CLK;
	sef_peer u_peer (.ss_n(ss_n), .sck(sck), .mosi(mosi));
	sef_flags u_dut (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .CE(1'b1), .CTL_WR(CTL_WR),
		.CTL_WDATA(CTL_WDATA), .STAT_RD(STAT_RD), .DATA_WR(DATA_WR), .DATA_RD(DATA_RD),
		.DATA_WDATA(DATA_WDATA), .SS_N(ss_n), .SCK_IN(sck), .MOSI_IN(mosi), .CTL_Q(CTL_Q),
		.RX_DATA(RX_DATA), .TRANSFER_DONE(TRANSFER_DONE), .WRITE_COLL(WRITE_COLL),
		.SELECT_ABORT(SELECT_ABORT), .MODE_FAULT(MODE_FAULT), .TX_IRQ(TX_IRQ),
		.RXERR_IRQ(RXERR_IRQ), .SPI_IRQ(SPI_IRQ), .MISO_OUT(MISO_OUT), .MISO_OE_N(MISO_OE_N),
		.SCK_OUT(SCK_OUT), .MOSI_OUT(MOSI_OUT));
	// slave view of the master link: mosi taken at each sck rise
	always @(negedge CORE_CLK) begin
		sck_q <= SCK_OUT;
		if (SCK_OUT && !sck_q) cap <= {cap[6:0], MOSI_OUT};
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// s: ctl write, status read, data write, data read
	task cpu(input logic [3:0] s, input logic [7:0] d);
		@(posedge CORE_CLK);
		{CTL_WR, STAT_RD, DATA_WR, DATA_RD} <= s;
		CTL_WDATA <= d;
		DATA_WDATA <= d;
		@(posedge CORE_CLK);
		{CTL_WR, STAT_RD, DATA_WR, DATA_RD} <= 4'h0;
		repeat (6) @(posedge CORE_CLK);
		#1;
	endtask
	task nt;
		t++;
		$display("test %0d ended", t);
	endtask
	task wdone;
		for (int i = 0; i < 300 && TRANSFER_DONE !== 1'b1; i++) @(posedge CORE_CLK);
		#1;
	endtask
	task test_done;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		test_done;
	end
	initial begin
		repeat (6) @(posedge CORE_CLK);
		ARST_N <= 1'b1;
		#1 chk(CTL_Q, 8'h14);
		chk({TRANSFER_DONE, WRITE_COLL, SELECT_ABORT, MODE_FAULT}, 8'h00);
		nt;
		b0 = $random(seed);
		b1 = $random(seed);
		cpu(4'h8, 8'h60);
		chk(MISO_OE_N, 8'h01);
		cpu(4'h2, b1);
		u_peer.sel(1'b0);
		cpu(4'h0, 8'h00);
		chk({MISO_OE_N, MISO_OUT}, {7'h00, b1[7]});
		u_peer.send(b0, 8);
		wdone;
		chk(RX_DATA, b0);
		chk(SPI_IRQ, 8'h01);
		u_peer.send(b1, 8);
		chk(RX_DATA, b0);
		chk({WRITE_COLL, SELECT_ABORT, MODE_FAULT, RXERR_IRQ}, 8'h00);
		cpu(4'h4, 8'h00);
		cpu(4'h1, 8'h00);
		chk(TRANSFER_DONE, 8'h00);
		nt;
		u_peer.send(b1, 5);
		chk(SELECT_ABORT, 8'h01);
		chk(SPI_IRQ, 8'h00);
		cpu(4'h8, 8'h00);
		chk(SELECT_ABORT, 8'h00);
		nt;
		cpu(4'h8, 8'h70);
		u_peer.sel(1'b0);
		cpu(4'h0, 8'h00);
		chk(MODE_FAULT, 8'h00);
		cpu(4'h8, 8'h50);
		chk(MODE_FAULT, 8'h01);
		chk(CTL_Q, 8'h00);
		chk(RXERR_IRQ, 8'h01);
		u_peer.sel(1'b1);
		cpu(4'h8, 8'h60);
		chk(MODE_FAULT, 8'h01);
		chk(RXERR_IRQ, 8'h00);
		cpu(4'h4, 8'h00);
		cpu(4'h8, 8'h70);
		chk(MODE_FAULT, 8'h00);
		chk(CTL_Q, 8'h70);
		nt;
		cpu(4'h2, b0);
		cpu(4'h2, b1);
		chk(WRITE_COLL, 8'h01);
		chk(SPI_IRQ, 8'h00);
		wdone;
		chk(TRANSFER_DONE, 8'h01);
		chk(cap, b0);
		cpu(4'h4, 8'h00);
		cpu(4'h1, 8'h00);
		chk(WRITE_COLL, 8'h00);
		nt;
		test_done;
	end
endmodule // sef_flags_test
`default_nettype wire
